// File: rtl/adcc_top.sv
// Contract
// - Result is a 10-bit unsigned code
// - Right-justified result fills pair low
// - Left-justified result fills pair high
// - Unused result bits read zero
// - Result bytes update at conversion end
// - Eight-bit mode converts eight MSBs only
// - Eight-bit mode ignores justification select
// - Eight-bit conversion two ticks shorter
// - Conversion clock divided from system clock
// - Rate never above 500 ksps
// - Select field picks the start source
// - Software start by writing busy bit
// - Timer 0, 1 or 2 overflow starts
// - External pin rising edge starts
// - Busy bit high throughout conversion
// - Busy fall sets done, requests interrupt
// - Result valid while done flag set
// - Timer 2 width picks overflow byte
//
// The address map and the AHB-Lite slave port were left to the implementer.
`include "adcc_map.svh"
`timescale 1ns/10ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter int BITS = 10,
  parameter int DIV_W = 5
) (
  // AHB-Lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Start sources
  input wire logic t0_ovf,
  input wire logic t1_ovf,
  input wire logic t2_low_ovf,
  input wire logic t2_high_ovf,
  input wire logic ext_start_pin,
  // Converter analog side
  input wire logic cmp_in,
  output logic [BITS-1:0] dac_code,
  output logic conv_in_progress,
  // Interrupt request
  output logic conv_irq_req
);

  // ---------------------------------------------------------------
  // Timing constants
  // ---------------------------------------------------------------
  // Least hclk count per conversion that keeps the rate at the cap
  localparam int MinConvCyc =
    (`ADCC_CLK_HZ + `ADCC_MAX_SPS - 1) / `ADCC_MAX_SPS;
  // Shortest conversion in converter ticks (eight-bit mode)
  localparam int ShortTicks = `ADCC_TRACK_TICKS + BITS - 2;
  // Rounded up so an exact fit still meets the ceiling
  localparam int MinRatioI = (MinConvCyc + ShortTicks - 1) / ShortTicks;
  localparam logic [DIV_W:0] MinRatio = (DIV_W+1)'(MinRatioI);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Software-visible state; the busy bit lives in the engine
  logic [2:0] src_q;
  logic irq_en_q;
  logic done_q;
  logic ljst_q;
  logic mode8_q;
  logic t2_wide_q;
  logic [DIV_W-1:0] div_q;
  logic [7:0] res_hi_q;
  logic [7:0] res_lo_q;
  logic [31:0] rdata_q;

  // ---------------------------------------------------------------
  // Bus address phase capture
  // ---------------------------------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic acc;
  logic rd_acc;
  logic wr_acc;

  assign acc = hsel && hready && htrans[1];
  assign rd_acc = acc && !hwrite;
  assign wr_acc = acc && hwrite;
  // Every register answers at once, so the slave never stretches a phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // The address is latched every cycle; only wr_pend_q gives it meaning
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_acc;
      wr_addr_q <= haddr;
    end
  end

  // ---------------------------------------------------------------
  // Write decode (data phase)
  // ---------------------------------------------------------------
  logic wr_ctrl;
  logic wr_cfg;
  logic [2:0] wr_src;
  logic wr_busy_one;
  logic wr_done_zero;
  logic wr_ie;
  logic wr_ljst;
  logic wr_mode8;
  logic wr_t2w;
  logic [DIV_W-1:0] wr_div;

  assign wr_ctrl = wr_pend_q && (wr_addr_q == `ADCC_CTRL_OFS);
  assign wr_cfg = wr_pend_q && (wr_addr_q == `ADCC_CFG_OFS);
  assign wr_src = hwdata[`ADCC_CTRL_SRC_HI:`ADCC_CTRL_SRC_LO];
  assign wr_busy_one = wr_ctrl && hwdata[`ADCC_CTRL_BUSY];
  assign wr_done_zero = wr_ctrl && !hwdata[`ADCC_CTRL_DONE];
  assign wr_ie = hwdata[`ADCC_CTRL_IE];
  assign wr_ljst = hwdata[`ADCC_CFG_LJST];
  assign wr_mode8 = hwdata[`ADCC_CFG_8BIT];
  assign wr_t2w = hwdata[`ADCC_CFG_T2W];
  assign wr_div = hwdata[`ADCC_CFG_DIV_HI:`ADCC_CFG_DIV_LO];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_q <= `ADCC_SRC_RST;
      irq_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      src_q <= wr_src;
      irq_en_q <= wr_ie;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ljst_q <= 1'b0;
      mode8_q <= 1'b0;
      t2_wide_q <= 1'b0;
      div_q <= `ADCC_DIV_RST;
    end else if (wr_cfg) begin
      ljst_q <= wr_ljst;
      mode8_q <= wr_mode8;
      t2_wide_q <= wr_t2w;
      div_q <= wr_div;
    end
  end

  // ---------------------------------------------------------------
  // Start source selection
  // ---------------------------------------------------------------
  logic ext_q;
  logic ext_rise;
  logic t2_ovf;
  logic sw_start;
  logic start_evt;
  logic start_any;
  logic start;
  logic busy;

  // Held at the pin's idle low level in reset, so no false edge follows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_start_pin;
    end
  end

  assign ext_rise = ext_start_pin && !ext_q;
  assign t2_ovf = t2_wide_q ? t2_high_ovf : t2_low_ovf;
  assign sw_start = wr_busy_one && (wr_src == ADCC_SRC_SW);

  always_comb begin
    case (adcc_src_t'(src_q))
      // Software starts are merged below, outside the source case
      ADCC_SRC_SW: start_evt = 1'b0;
      ADCC_SRC_T0: start_evt = t0_ovf;
      ADCC_SRC_T2: start_evt = t2_ovf;
      ADCC_SRC_T1: start_evt = t1_ovf;
      ADCC_SRC_EXT: start_evt = ext_rise;
      default: start_evt = 1'b0;
    endcase
  end

  // A software start obeys the select code written in the same word,
  // not the one held before it, so it cannot wait for the source case.
  assign start_any = start_evt || sw_start;
  assign start = start_any && !busy;

  // ---------------------------------------------------------------
  // Conversion clock divider
  // ---------------------------------------------------------------
  // The divider counts hclk so every register stays on one clock;
  // the converter only advances on the one-cycle tick.
  logic [DIV_W:0] ratio_sel;
  logic [DIV_W:0] ratio;
  logic [DIV_W:0] div_cnt_q;
  logic tick;

  assign ratio_sel = {1'b0, div_q} + (DIV_W+1)'(1);
  // A divider that would outrun the rate ceiling is clamped, not refused,
  // so software always gets a finished conversion.
  // rate cap
  assign ratio = (ratio_sel < MinRatio) ? MinRatio : ratio_sel;
  assign tick = busy && (div_cnt_q + (DIV_W+1)'(1) >= ratio);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= '0;
    end else if (!busy || tick) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + (DIV_W+1)'(1);
    end
  end

  // ---------------------------------------------------------------
  // Successive approximation engine
  // ---------------------------------------------------------------
  logic conv_end;
  logic [BITS-1:0] code;

  adcc_sar #(
    .BITS(BITS)
  ) u_sar (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .start(start),
    .short_mode(mode8_q),
    .cmp_in(cmp_in),
    .dac_code(dac_code),
    .busy(busy),
    .done(conv_end),
    .code(code)
  );

  assign conv_in_progress = busy;

  // ---------------------------------------------------------------
  // Result formatting
  // ---------------------------------------------------------------
  logic [7:0] fmt_hi;
  logic [7:0] fmt_lo;
  logic [7:0] right_hi;
  logic [7:0] right_lo;
  logic [7:0] left_hi;
  logic [7:0] left_lo;
  logic [7:0] short_hi;

  assign right_hi = {6'h00, code[BITS-1 -: 2]};
  assign right_lo = code[7:0];
  assign left_hi = code[BITS-1 -: 8];
  assign left_lo = {code[1:0], 6'h00};
  assign short_hi = code[BITS-1 -: 8];
  assign fmt_hi = mode8_q ? short_hi : (ljst_q ? left_hi : right_hi);
  assign fmt_lo = mode8_q ? 8'h00 : (ljst_q ? left_lo : right_lo);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_hi_q <= 8'h00;
      res_lo_q <= 8'h00;
    end else if (conv_end) begin
      res_hi_q <= fmt_hi;
      res_lo_q <= fmt_lo;
    end
  end

  // ---------------------------------------------------------------
  // Done flag and interrupt request
  // ---------------------------------------------------------------
  // A completion must not be lost to a clear written in the same cycle
  // set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (conv_end) begin
      done_q <= 1'b1;
    end else if (wr_done_zero) begin
      done_q <= 1'b0;
    end
  end

  assign conv_irq_req = done_q && irq_en_q;

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  logic [31:0] ctrl_rd;
  logic [31:0] cfg_rd;
  logic [31:0] rd_mux;

  assign ctrl_rd = {26'h0, irq_en_q, src_q, done_q, busy};
  assign cfg_rd = {24'h0, div_q, t2_wide_q, mode8_q, ljst_q};

  always_comb begin
    case (haddr)
      `ADCC_CTRL_OFS: rd_mux = ctrl_rd;
      `ADCC_CFG_OFS: rd_mux = cfg_rd;
      `ADCC_RHI_OFS: rd_mux = {24'h0, res_hi_q};
      `ADCC_RLO_OFS: rd_mux = {24'h0, res_lo_q};
      // Unmapped offsets read zero
      default: rd_mux = 32'h0;
    endcase
  end

  // Read data is caught at the address phase so it comes from a flop;
  // a write in the preceding data phase is therefore not yet visible.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0;
    end else if (rd_acc) begin
      rdata_q <= rd_mux;
    end
  end

endmodule // adcc_top

// File: rtl/adcc_map.svh
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ADCC_CTRL_OFS 8'h00
`define ADCC_CFG_OFS 8'h04
`define ADCC_RHI_OFS 8'h08
`define ADCC_RLO_OFS 8'h0c

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define ADCC_CTRL_BUSY 0
`define ADCC_CTRL_DONE 1
`define ADCC_CTRL_SRC_LO 2
`define ADCC_CTRL_SRC_HI 4
`define ADCC_CTRL_IE 5

// ---------------------------------------------------------------
// Configuration register fields
// ---------------------------------------------------------------
`define ADCC_CFG_LJST 0
`define ADCC_CFG_8BIT 1
`define ADCC_CFG_T2W 2
`define ADCC_CFG_DIV_LO 3
`define ADCC_CFG_DIV_HI 7

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define ADCC_SRC_RST 3'h0
`define ADCC_DIV_RST 5'h1f

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ADCC_CLK_HZ 10000000
`define ADCC_MAX_SPS 500000
`define ADCC_TRACK_TICKS 1

`endif

// File: rtl/adcc_pkg.sv
package adcc_pkg;

  // Start source codes, in select-field order
  typedef enum logic [2:0] {
    ADCC_SRC_SW = 3'h0,
    ADCC_SRC_T0 = 3'h1,
    ADCC_SRC_T2 = 3'h2,
    ADCC_SRC_T1 = 3'h3,
    ADCC_SRC_EXT = 3'h4
  } adcc_src_t;

  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_TRACK,
    ADCC_CONV
  } adcc_state_t;

endpackage

// File: rtl/adcc_sar.sv
`timescale 1ns/10ps
module adcc_sar
  import adcc_pkg::*;
#(
  parameter int BITS = 10
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic tick,
  input wire logic start,
  input wire logic short_mode,
  // Analog side
  input wire logic cmp_in,
  output logic [BITS-1:0] dac_code,
  // Status
  output logic busy,
  output logic done,
  output logic [BITS-1:0] code
);

  adcc_state_t state_q, state_d;
  logic [BITS-1:0] code_q, code_d;
  logic [BITS-1:0] mask_q, mask_d;
  logic [BITS-1:0] trial;
  logic [BITS-1:0] keep;
  logic last_bit;
  logic done_q, done_d;

  // ---------------------------------------------------------------
  // Trial code per bit
  // ---------------------------------------------------------------
  for (genvar i = 0; i < BITS; i++) begin : g_bit
    assign trial[i] = code_q[i] | mask_q[i];
    assign keep[i] = mask_q[i] ? cmp_in : code_q[i];
  end

  assign last_bit = short_mode ? mask_q[2] : mask_q[0];
  assign dac_code = trial;
  assign busy = (state_q != ADCC_IDLE);
  assign done = done_q;
  assign code = code_q;

  always_comb begin
    state_d = state_q;
    code_d = code_q;
    mask_d = mask_q;
    done_d = 1'b0;
    case (state_q)
      ADCC_IDLE: begin
        if (start) begin
          state_d = ADCC_TRACK;
          code_d = '0;
          mask_d = {1'b1, {(BITS-1){1'b0}}};
        end
      end
      ADCC_TRACK: begin
        if (tick) begin
          state_d = ADCC_CONV;
        end
      end
      ADCC_CONV: begin
        if (tick) begin
          code_d = keep;
          mask_d = mask_q >> 1;
          if (last_bit) begin
            state_d = ADCC_IDLE;
            done_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = ADCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ADCC_IDLE;
      code_q <= '0;
      mask_q <= '0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      code_q <= code_d;
      mask_q <= mask_d;
      done_q <= done_d;
    end
  end

endmodule // adcc_sar

// File: verification/adcc_monitor.sv
`timescale 1ns/10ps
module adcc_monitor
  import adcc_pkg::*;
(
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Starts and status
  input wire logic t0_ovf,
  input wire logic t1_ovf,
  input wire logic t2_low_ovf,
  input wire logic t2_high_ovf,
  input wire logic ext_start_pin,
  input wire logic conv_in_progress,
  input wire logic conv_irq_req
);
  // --------
  // Shadow of the written setup
  // --------
  logic wc_q, wf_q, ext_q, t2w_q, e8_q, ie_q;
  logic [2:0] src_q;
  logic [4:0] div_q;
  logic [8:0] len_q;
  wire logic acc = hsel & hready & htrans[1] & hwrite;
  wire logic [5:0] rat = (div_q < 5'h02) ? 6'h03 : {1'b0, div_q} + 6'h01;
  wire logic [8:0] exp_len = rat * (e8_q ? 9'h009 : 9'h00b);
  wire logic t2_ev = t2w_q ? t2_high_ovf : t2_low_ovf;
  wire logic start_ev = (wc_q & hwdata[0] & hwdata[4:2] == 3'h0)
    | (src_q == ADCC_SRC_T0 & t0_ovf) | (src_q == ADCC_SRC_T1 & t1_ovf)
    | (src_q == ADCC_SRC_T2 & t2_ev)
    | (src_q == ADCC_SRC_EXT & ext_start_pin & !ext_q);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wc_q, wf_q, ext_q, t2w_q, e8_q, ie_q, src_q} <= 9'h000;
      div_q <= 5'h1f;
      len_q <= 9'h000;
    end else begin
      wc_q <= acc & (haddr == 8'h00);
      wf_q <= acc & (haddr == 8'h04);
      ext_q <= ext_start_pin;
      if (wc_q) {ie_q, src_q} <= hwdata[5:2];
      if (wf_q) {div_q, t2w_q, e8_q} <= hwdata[7:1];
      len_q <= conv_in_progress ? len_q + 9'h001 : 9'h000;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_okay_resp: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  a_sw_start: assert property (
    wc_q && hwdata[0] && hwdata[4:2] == 3'h0 |=> conv_in_progress)
    else $error("software start missed");
  // Starts landing while busy are excluded: those must be ignored
  a_hw_start: assert property (
    start_ev && !conv_in_progress |=> conv_in_progress)
    else $error("selected start event missed");
  a_no_stray: assert property (
    !conv_in_progress && !start_ev |=> !conv_in_progress)
    else $error("conversion began without selected event");
  a_busy_exact: assert property (
    $fell(conv_in_progress) |-> len_q == exp_len)
    else $error("conversion length wrong");
  a_rate_floor: assert property (
    $fell(conv_in_progress) |-> len_q >= 9'h014)
    else $error("conversion faster than rate ceiling");
  a_busy_holds: assert property (
    $rose(conv_in_progress) |-> conv_in_progress [*8])
    else $error("busy dropped early");
  a_busy_ends: assert property (
    $rose(conv_in_progress) |-> ##[27:352] !conv_in_progress)
    else $error("busy never ended");
  // Done is set one edge after busy falls; enable writes are excluded
  a_irq_at_fall: assert property (
    $rose(conv_irq_req) && !$past(wc_q) |-> $past(conv_in_progress, 2))
    else $error("interrupt not tied to busy fall");
  a_irq_raised: assert property (
    $fell(conv_in_progress) && ie_q |=> conv_irq_req)
    else $error("enabled interrupt not raised at busy fall");
endmodule // adcc_monitor

bind adcc_top adcc_monitor mon (.*);

// File: verification/adcc_far.sv
`timescale 1ns/10ps
module adcc_far (
  // Clock
  input wire logic hclk,
  // Start sources
  output logic t0_ovf,
  output logic t1_ovf,
  output logic t2_low_ovf,
  output logic t2_high_ovf,
  output logic ext_start_pin,
  // Comparator
  input wire logic [9:0] dac_code,
  output logic cmp_in
);
  logic [9:0] vin;
  assign cmp_in = vin >= dac_code;
  initial begin
    {t0_ovf, t1_ovf, t2_low_ovf, t2_high_ovf, ext_start_pin} = 5'h00;
    vin = 10'h000;
  end
  task automatic fire(input int k);
    case (k)
      1: t0_ovf <= 1'b1;
      2: t2_low_ovf <= 1'b1;
      3: t1_ovf <= 1'b1;
      4: ext_start_pin <= 1'b1;
      default: t2_high_ovf <= 1'b1;
    endcase
    @(posedge hclk);
    {t0_ovf, t1_ovf, t2_low_ovf, t2_high_ovf, ext_start_pin} <= 5'h00;
    // One low cycle so back-to-back pulses stay distinct edges
    @(posedge hclk);
  endtask
endmodule // adcc_far

// File: verification/adc_conversion_control_bench.sv
`timescale 1ns/10ps
module adc_conversion_control_bench;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, busy, irq, cmp_in;
  logic t0_ovf, t1_ovf, t2_low_ovf, t2_high_ovf, ext_start_pin;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, r;
  logic [9:0] dac_code;
  int failures = 0;
  int n_tests = 0;
  logic [7:0] cfg_t [8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h02, 8'h03,
    8'h08, 8'h19};
  logic [9:0] vin_t [8] = '{10'h3ff, 10'h200, 10'h3ff, 10'h200, 10'h3ff,
    10'h155, 10'h100, 10'h2a5};
  always #50 hclk = ~hclk;
  adcc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .t0_ovf(t0_ovf), .t1_ovf(t1_ovf),
    .t2_low_ovf(t2_low_ovf), .t2_high_ovf(t2_high_ovf),
    .ext_start_pin(ext_start_pin), .cmp_in(cmp_in), .dac_code(dac_code),
    .conv_in_progress(busy), .conv_irq_req(irq));
  adcc_far far (.hclk(hclk), .t0_ovf(t0_ovf), .t1_ovf(t1_ovf),
    .t2_low_ovf(t2_low_ovf), .t2_high_ovf(t2_high_ovf),
    .ext_start_pin(ext_start_pin), .dac_code(dac_code), .cmp_in(cmp_in));
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  task rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      failures++;
      end_of_test;
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  // Pins are looked at mid-cycle, away from the launching edge
  task mid_chk(input logic eb, input logic ei);
    @(negedge hclk);
    chk("busy pin", {31'h0, eb}, {31'h0, busy});
    chk("irq pin", {31'h0, ei}, {31'h0, irq});
    @(posedge hclk);
  endtask
  task run(input logic [7:0] cfg, input logic [2:0] s, input logic ie,
    input logic [9:0] v);
    logic [31:0] q;
    logic [15:0] e;
    int k, good;
    e = cfg[1] ? {v[9:2], 8'h00} : cfg[0] ? {v, 6'h00} : {6'h00, v};
    good = (s == 3'h2 && cfg[2]) ? 5 : s;
    far.vin = v;
    xfer(1'b1, 8'h04, {24'h0, cfg}, q);
    xfer(1'b1, 8'h00, {26'h0, ie, s, 1'b0, s == 3'h0}, q);
    if (s == 3'h0) begin
      xfer(1'b1, 8'h00, {26'h0, ie, 5'h01}, q);
    end else begin
      far.fire(s == 3'h2 ? 7 - good : s % 4 + 1);
      mid_chk(1'b0, 1'b0);
      far.fire(good);
      far.fire(good);
    end
    rd(8'h00, {26'h0, ie, s, 2'b01}, "ctrl busy");
    k = 0;
    do begin
      xfer(1'b0, 8'h00, 32'h0, q);
      k++;
    end while (q[1] !== 1'b1 && k < 100);
    if (q[1] !== 1'b1) begin
      failures++;
      end_of_test;
    end
    chk("ctrl done", {26'h0, ie, s, 2'b10}, q);
    rd(8'h08, {24'h0, e[15:8]}, "result high");
    rd(8'h0c, {24'h0, e[7:0]}, "result low");
  endtask
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = 45'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, 32'h0, "ctrl reset");
    rd(8'h04, 32'hf8, "cfg reset");
    rd(8'h10, 32'h0, "unmapped");
    xfer(1'b1, 8'h08, 32'hff, r);
    rd(8'h08, 32'h0, "result high read-only");
    for (int i = 0; i < 8; i++) begin
      run(cfg_t[i], 3'h0, 1'b0, vin_t[i]);
    end
    for (int i = 0; i < 5; i++) begin
      run(i == 4 ? 8'h04 : 8'h00, i == 4 ? 3'h2 : 3'(i + 1), 1'b0,
        10'h2a5);
    end
    run(8'h00, 3'h0, 1'b1, 10'h3ff);
    mid_chk(1'b0, 1'b1);
    xfer(1'b1, 8'h00, 32'h20, r);
    mid_chk(1'b0, 1'b0);
    run(8'h00, 3'h0, 1'b0, 10'h001);
    mid_chk(1'b0, 1'b0);
    end_of_test;
  end
endmodule // adc_conversion_control_bench
